/* pkg/pmcp_pkg.sv */
/*
  pmcp_pkg: constants for the program memory code protection block.
  Assumes a 21-bit program address space and byte-wide configuration space.
*/
`default_nettype none
package pmcp_pkg;
  // memory map
  localparam logic [20:0] BOOT_END      = 21'h0007FF;
  localparam logic [20:0] REGION0_BASE  = 21'h000800;
  localparam logic [20:0] REGION1_BASE  = 21'h004000;
  localparam logic [20:0] REGION2_BASE  = 21'h008000;
  localparam logic [20:0] REGION3_BASE  = 21'h00C000;
  localparam logic [20:0] TOP_48K       = 21'h00C000;
  localparam logic [20:0] TOP_64K       = 21'h010000;
  localparam logic [20:0] CFG_BASE      = 21'h00FF00;
  // configuration space addresses (full 22-bit form)
  localparam logic [21:0] CFG_SPACE_LO  = 22'h300000;
  localparam logic [21:0] CFG_SPACE_HI  = 22'h3000FF;
  localparam logic [21:0] ADDR_CP_LOW   = 22'h300008;
  localparam logic [21:0] ADDR_CP_HIGH  = 22'h300009;
  localparam logic [21:0] ADDR_WP_LOW   = 22'h30000A;
  localparam logic [21:0] ADDR_WP_HIGH  = 22'h30000B;
  localparam logic [21:0] ADDR_TR_LOW   = 22'h30000C;
  localparam logic [21:0] ADDR_TR_HIGH  = 22'h30000D;
  localparam logic [21:0] ID_BASE       = 22'h200000;
  localparam logic [21:0] ID_LAST       = 22'h200007;
  localparam int          ID_COUNT      = 8;
  // field positions
  localparam int          BIT_EEPROM    = 7;
  localparam int          BIT_BOOT      = 6;
  localparam int          BIT_CONFIG    = 5;
  localparam int          BIT_REGION3   = 3;
  localparam logic [7:0]  MASK_LOW      = 8'h0F;
  localparam logic [7:0]  MASK_CP_HIGH  = 8'hC0;
  localparam logic [7:0]  MASK_WP_HIGH  = 8'hE0;
  localparam logic [7:0]  MASK_TR_HIGH  = 8'h40;
  // unprogrammed value of every protection bit; reset masks off the unused bits of each byte
  localparam logic [7:0]  ERASED        = 8'hFF;
  localparam logic [7:0]  ID_RESET      = 8'hFF;
  localparam int          NUM_REGIONS   = 5;
  localparam int          REG_BOOT      = 4;
  // who is asking
  typedef enum logic [1:0] {
    SRC_CPU,
    SRC_TABLE,
    SRC_EXTERNAL
  } pmcp_src_type;
endpackage : pmcp_pkg
`default_nettype wire

/* rtl/pmcp_sync.sv */
/*
  pmcp_sync: three-flop synchroniser with agreement filter for pin inputs.
  Assumes the pin is asynchronous to mclk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module pmcp_sync (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // first flop feeds only the second; output moves when second and third agree
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r      <= 1'b0;
      s2_r      <= 1'b0;
      s3_r      <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end
endmodule : pmcp_sync
`default_nettype wire

/* rtl/pmcp_core.sv */
/*
  pmcp_core: protection checks for program flash, data eeprom, config bytes
  and id locations, plus the six protection bytes and the debug reservation.
  Assumes the memory arrays sit outside; this block grants or refuses each
  access one cycle after the request and returns read data for the bytes it
  holds. Program mode is signalled by the high-voltage pin, a level.
*/
// Function
// [R1] boot region 2 Kbytes at address zero
// [R2] four binary regions from 000800h, 64K adds fourth
// [R3] each region: code, write, table-read protect
// [R4] boot writes blocked when boot bit zero
// [R5] region write-protect bits at 30000Ah bits 3-0
// [R6] eeprom, boot, config write bits at 30000Bh
// [R7] erased bits read one; clearing enables protection
// [R8] programmer keeps fourth region bits set on 48K
// [R9] config space writes blocked when config bit zero
// [R10] config write bit changes only in program mode; the code also takes external config writes outside program mode
// [R11] eeprom code protect refuses external access
// [R12] eeprom write protect refuses all writes
// [R13] code and table-read bytes at fixed addresses
// [R14] eight id bytes read and write
// [R15] id bytes readable despite code protection
// [R16] programming uses one clock, one data line
// [R17] debug enabled only when debug bit zero
// [R18] debug reserves two pins, two stack levels
// [R19] unimplemented program space reads zero, unwritable
`timescale 1ns/1ns
`default_nettype none
module pmcp_core (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        is_64k_in,
  input  wire logic        program_voltage_pin_in,
  input  wire logic        debug_clock_pin_in,
  input  wire logic        debug_data_pin_in,
  input  wire logic        debug_config_bit_in,
  input  wire logic        req_in,
  input  wire logic        req_write_in,
  input  wire logic [1:0]  req_src_in,
  input  wire logic        req_eeprom_in,
  input  wire logic [21:0] req_addr_in,
  input  wire logic [7:0]  req_wdata_in,
  input  wire logic [20:0] req_pc_in,
  output logic             grant_out,
  output logic             refuse_out,
  output logic [7:0]       rdata_out,
  output logic             rdata_valid_out,
  output logic             debug_enable_out,
  output logic             pins_reserved_out,
  output logic [1:0]       stack_reserved_out,
  output logic             debug_clock_out,
  output logic             debug_data_out
);
  logic [7:0] code_protect_low_r;
  logic [7:0] code_protect_high_r;
  logic [7:0] write_protect_low_r;
  logic [7:0] write_protect_high_r;
  logic [7:0] table_read_protect_low_r;
  logic [7:0] table_read_protect_high_r;
  logic [7:0] id_mem_r [pmcp_pkg::ID_COUNT];
  logic       prog_mode;
  logic       dbg_clk_sync;
  logic       dbg_data_sync;
  logic       debug_en_r;

  // program mode pin and the two serial lines are asynchronous pins
  pmcp_sync u_sync_vpp (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .pin_in    (program_voltage_pin_in),
    .level_out (prog_mode)
  );
  pmcp_sync u_sync_clk (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .pin_in    (debug_clock_pin_in),
    .level_out (dbg_clk_sync)
  );
  pmcp_sync u_sync_dat (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .pin_in    (debug_data_pin_in),
    .level_out (dbg_data_sync)
  );

  // region decode of the program address
  logic [4:0]  region_hit;
  logic        implemented;
  logic [20:0] paddr;
  logic        is_prog;
  logic        is_cfg;
  logic        is_id;
  always_comb begin
    paddr      = req_addr_in[20:0];
    is_prog    = !req_eeprom_in && (req_addr_in[21] == 1'b0) && (req_addr_in < pmcp_pkg::ID_BASE);
    is_cfg     = !req_eeprom_in && (req_addr_in >= pmcp_pkg::CFG_SPACE_LO)
                 && (req_addr_in <= pmcp_pkg::CFG_SPACE_HI);
    is_id      = !req_eeprom_in && (req_addr_in >= pmcp_pkg::ID_BASE)
                 && (req_addr_in <= pmcp_pkg::ID_LAST);
    implemented = paddr < (is_64k_in ? pmcp_pkg::TOP_64K : pmcp_pkg::TOP_48K); // see [R19]
    region_hit = 5'h00;
    if (paddr <= pmcp_pkg::BOOT_END) begin
      region_hit[pmcp_pkg::REG_BOOT] = 1'b1; // see [R1]
    end else if (paddr < pmcp_pkg::REGION1_BASE) begin
      region_hit[0] = 1'b1; // see [R2]
    end else if (paddr < pmcp_pkg::REGION2_BASE) begin
      region_hit[1] = 1'b1;
    end else if (paddr < pmcp_pkg::REGION3_BASE) begin
      region_hit[2] = 1'b1;
    end else if (is_64k_in) begin
      region_hit[3] = 1'b1; // see [R2]
    end
  end

  // per-region protect vectors: index 4 is the boot region
  logic [4:0] cp_vec;
  logic [4:0] wp_vec;
  logic [4:0] tr_vec;
  always_comb begin
    cp_vec = {code_protect_high_r[pmcp_pkg::BIT_BOOT], code_protect_low_r[3:0]}; // see [R3]
    wp_vec = {write_protect_high_r[pmcp_pkg::BIT_BOOT], write_protect_low_r[3:0]}; // see [R3]
    tr_vec = {table_read_protect_high_r[pmcp_pkg::BIT_BOOT],
              table_read_protect_low_r[3:0]}; // see [R3]
  end

  // the region of the executing code, for table reads across regions
  logic pc_in_same;
  always_comb begin
    if (req_pc_in <= pmcp_pkg::BOOT_END) begin
      pc_in_same = region_hit[pmcp_pkg::REG_BOOT];
    end else if (req_pc_in < pmcp_pkg::REGION1_BASE) begin
      pc_in_same = region_hit[0];
    end else if (req_pc_in < pmcp_pkg::REGION2_BASE) begin
      pc_in_same = region_hit[1];
    end else if (req_pc_in < pmcp_pkg::REGION3_BASE) begin
      pc_in_same = region_hit[2];
    end else begin
      pc_in_same = region_hit[3];
    end
  end

  // access decision; zero bit means protected
  logic allow;
  logic is_ext;
  logic is_tbl;
  always_comb begin
    is_ext = (req_src_in == 2'(pmcp_pkg::SRC_EXTERNAL));
    is_tbl = (req_src_in == 2'(pmcp_pkg::SRC_TABLE));
    allow  = 1'b0;
    if (req_eeprom_in) begin
      if (req_write_in && !write_protect_high_r[pmcp_pkg::BIT_EEPROM]) begin
        allow = 1'b0; // see [R12]
      end else if (is_ext && !code_protect_high_r[pmcp_pkg::BIT_EEPROM]) begin
        allow = 1'b0; // see [R11]
      end else begin
        allow = 1'b1;
      end
    end else if (is_id) begin
      allow = 1'b1; // see [R14] [R15]
    end else if (is_cfg) begin
      allow = !req_write_in || (write_protect_high_r[pmcp_pkg::BIT_CONFIG]
              && (prog_mode || is_ext)); // see [R9] [R10]
    end else if (is_prog) begin
      if (!implemented) begin
        allow = !req_write_in; // reads return zero, see [R19]
      end else if (req_write_in) begin
        allow = |(region_hit & wp_vec); // see [R4] [R7]
      end else if (is_ext) begin
        allow = |(region_hit & cp_vec);
      end else if (is_tbl && !pc_in_same) begin
        allow = |(region_hit & tr_vec);
      end else begin
        allow = 1'b1;
      end
    end
  end

  // one-cycle answer to each request
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      grant_out  <= 1'b0;
      refuse_out <= 1'b0;
    end else begin
      grant_out  <= req_in && allow;
      refuse_out <= req_in && !allow;
    end
  end

  // read data for protection bytes, id bytes and unimplemented space
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out       <= 8'h00;
      rdata_valid_out <= 1'b0;
    end else begin
      rdata_valid_out <= req_in && !req_write_in && allow && (is_cfg || is_id
                         || (is_prog && !implemented));
      unique case (req_addr_in)
        pmcp_pkg::ADDR_CP_LOW:  rdata_out <= code_protect_low_r;  // see [R13]
        pmcp_pkg::ADDR_CP_HIGH: rdata_out <= code_protect_high_r;
        pmcp_pkg::ADDR_WP_LOW:  rdata_out <= write_protect_low_r;  // see [R5]
        pmcp_pkg::ADDR_WP_HIGH: rdata_out <= write_protect_high_r; // see [R6]
        pmcp_pkg::ADDR_TR_LOW:  rdata_out <= table_read_protect_low_r;
        pmcp_pkg::ADDR_TR_HIGH: rdata_out <= table_read_protect_high_r;
        default: begin
          if (is_id) begin
            rdata_out <= id_mem_r[req_addr_in[2:0]]; // see [R15]
          end else begin
            rdata_out <= 8'h00;
          end
        end
      endcase
    end
  end

  // protection bytes: erased reads one, writes may only clear bits
  logic wr_ok;
  assign wr_ok = req_in && req_write_in && allow && is_cfg;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      code_protect_low_r        <= pmcp_pkg::ERASED & pmcp_pkg::MASK_LOW;     // see [R7]
      code_protect_high_r       <= pmcp_pkg::ERASED & pmcp_pkg::MASK_CP_HIGH;
      write_protect_low_r       <= pmcp_pkg::ERASED & pmcp_pkg::MASK_LOW;
      write_protect_high_r      <= pmcp_pkg::ERASED & pmcp_pkg::MASK_WP_HIGH;
      table_read_protect_low_r  <= pmcp_pkg::ERASED & pmcp_pkg::MASK_LOW;
      table_read_protect_high_r <= pmcp_pkg::ERASED & pmcp_pkg::MASK_TR_HIGH;
    end else if (wr_ok) begin
      unique case (req_addr_in)
        pmcp_pkg::ADDR_CP_LOW:
          code_protect_low_r <= code_protect_low_r & req_wdata_in & pmcp_pkg::MASK_LOW;
        pmcp_pkg::ADDR_CP_HIGH:
          code_protect_high_r <= code_protect_high_r & req_wdata_in & pmcp_pkg::MASK_CP_HIGH;
        pmcp_pkg::ADDR_WP_LOW:
          write_protect_low_r <= write_protect_low_r & req_wdata_in
                                 & pmcp_pkg::MASK_LOW; // see [R5]
        pmcp_pkg::ADDR_WP_HIGH:
          write_protect_high_r <= write_protect_high_r & req_wdata_in
                                  & pmcp_pkg::MASK_WP_HIGH; // see [R6]
        pmcp_pkg::ADDR_TR_LOW:
          table_read_protect_low_r <= table_read_protect_low_r & req_wdata_in
                                      & pmcp_pkg::MASK_LOW;
        pmcp_pkg::ADDR_TR_HIGH:
          table_read_protect_high_r <= table_read_protect_high_r & req_wdata_in
                                       & pmcp_pkg::MASK_TR_HIGH;
        default: ;
      endcase
    end
  end

  // id bytes are plain storage, not gated by code protection
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < pmcp_pkg::ID_COUNT; i++) begin
        id_mem_r[i] <= pmcp_pkg::ID_RESET;
      end
    end else if (req_in && req_write_in && is_id) begin
      id_mem_r[req_addr_in[2:0]] <= req_wdata_in; // see [R14]
    end
  end

  // debug enable registered every cycle from the config bit; a zero bit turns debug on
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      debug_en_r <= 1'b0;
    end else begin
      debug_en_r <= !debug_config_bit_in; // see [R17]
    end
  end

  // reservation of pins while debug runs or in program mode, and of stack while debug runs
  assign debug_enable_out   = debug_en_r;
  assign pins_reserved_out  = debug_en_r || prog_mode;            // see [R18]
  assign stack_reserved_out = debug_en_r ? 2'h2 : 2'h0;            // see [R18]
  // synchronised serial lines handed to the debug engine
  assign debug_clock_out    = pins_reserved_out & dbg_clk_sync;   // see [R16]
  assign debug_data_out     = pins_reserved_out & dbg_data_sync;  // see [R16]

  // assertions
  a_boot_write_block: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in && req_write_in && is_prog && region_hit[pmcp_pkg::REG_BOOT]
     && !wp_vec[pmcp_pkg::REG_BOOT])
      |=> refuse_out) else $error("boot write not refused"); // see [R4]
  a_eeprom_wp: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in && req_eeprom_in && req_write_in && !write_protect_high_r[pmcp_pkg::BIT_EEPROM])
      |=> refuse_out && !grant_out) else $error("eeprom write granted"); // see [R12]
  a_eeprom_cp: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in && req_eeprom_in && is_ext && !code_protect_high_r[pmcp_pkg::BIT_EEPROM])
      |=> refuse_out) else $error("external eeprom access granted"); // see [R11]
  a_cfg_wp: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in && req_write_in && is_cfg && !write_protect_high_r[pmcp_pkg::BIT_CONFIG])
      |=> refuse_out) else $error("config write granted"); // see [R9]
  a_id_read: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in && !req_write_in && is_id) |=> grant_out && rdata_valid_out)
    else $error("id read refused"); // see [R15]
  a_unimpl_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in && is_prog && !implemented && !req_write_in)
      |=> rdata_out == 8'h00 && rdata_valid_out) else $error("unimpl read nonzero"); // see [R19]
  a_unimpl_write: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in && is_prog && !implemented && req_write_in) |=> refuse_out)
    else $error("unimpl write granted"); // see [R19]
  a_bits_only_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(write_protect_low_r[0]) |-> 1'b0) else $error("protect bit set again"); // see [R7]
  a_wp_high_reserved: assert property (@(posedge mclk_in) disable iff (rst_in)
    write_protect_high_r[4:0] == 5'h00) else $error("reserved bits nonzero"); // see [R6]
  a_debug_stack: assert property (@(posedge mclk_in) disable iff (rst_in)
    debug_en_r |-> stack_reserved_out == 2'h2 && pins_reserved_out)
    else $error("debug resources not reserved"); // see [R18]
  a_debug_bit: assert property (@(posedge mclk_in) disable iff (rst_in)
    !debug_config_bit_in [*2] |-> debug_en_r) else $error("debug not enabled"); // see [R17]
  a_cfg_prog_mode: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in && req_write_in && is_cfg && !prog_mode && !is_ext) |=> refuse_out)
    else $error("config written outside program mode"); // see [R10]
endmodule : pmcp_core
`default_nettype wire

/* sim/pmcp_prog_model.sv */
/*
  pmcp_prog_model: external serial programmer on the clock, data and
  program-voltage pins of the protection block.
  Assumes the bench calls its tasks; the pins are asynchronous to mclk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module pmcp_prog_model (
  input  wire logic mclk_in,
  output logic      program_voltage_out,
  output logic      debug_clock_out,
  output logic      debug_data_out
);
  // idle: no high voltage, clock parked low
  initial begin
    program_voltage_out = 1'b0;
    debug_clock_out     = 1'b0;
    debug_data_out      = 1'b0;
  end

  // program mode is a plain level on the high-voltage pin
  task automatic set_program(input logic on);
    @(posedge mclk_in);
    #2 program_voltage_out = on;
  endtask : set_program

  // one byte, msb first; clock only moves inside the frame
  // each clock level stands two cycles, else the pin filter swallows it
  task automatic send_frame(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge mclk_in);
      #3 debug_data_out = b[i];
      @(posedge mclk_in);
      #3 debug_clock_out = 1'b1;
      repeat (2) @(posedge mclk_in);
      #3 debug_clock_out = 1'b0;
    end
    // released data line shows the inverse, not a stale copy
    debug_data_out = ~b[0];
  endtask : send_frame
endmodule : pmcp_prog_model
`default_nettype wire

/* sim/tb_pmcp_core.sv */
/*
  tb_pmcp_core: self-checking bench for the protection core.
  Assumes pmcp_pkg and pmcp_core compiled first; the programmer model
  drives the pins, the bench drives the request port.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_pmcp_core;
  logic        mclk_in    = 1'b0;
  logic        rst_in     = 1'b1;
  logic        is_64k     = 1'b1;
  logic        debug_cfg  = 1'b1;
  logic        req        = 1'b0;
  logic        req_write  = 1'b0;
  logic [1:0]  req_src    = 2'h0;
  logic        req_eeprom = 1'b0;
  logic [21:0] req_addr   = 22'h000000;
  logic [7:0]  req_wdata  = 8'h00;
  logic [20:0] req_pc     = 21'h000000;
  logic        vpp, pclk, pdat;
  logic        grant, refuse, rdv, dbg_en, pins_res, dclk_o, ddat_o;
  logic [7:0]  rdata, r_data;
  logic [1:0]  stack_res;
  logic        r_valid;
  int          miscompares = 0;
  int          tests_run   = 0;
  localparam logic [1:0] CPU = pmcp_pkg::SRC_CPU;
  localparam logic [1:0] TBL = pmcp_pkg::SRC_TABLE;
  localparam logic [1:0] EXT = pmcp_pkg::SRC_EXTERNAL;

  pmcp_core pmcp_core_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .is_64k_in(is_64k),
    .program_voltage_pin_in(vpp), .debug_clock_pin_in(pclk), .debug_data_pin_in(pdat),
    .debug_config_bit_in(debug_cfg), .req_in(req), .req_write_in(req_write),
    .req_src_in(req_src), .req_eeprom_in(req_eeprom), .req_addr_in(req_addr),
    .req_wdata_in(req_wdata), .req_pc_in(req_pc), .grant_out(grant),
    .refuse_out(refuse), .rdata_out(rdata), .rdata_valid_out(rdv),
    .debug_enable_out(dbg_en), .pins_reserved_out(pins_res),
    .stack_reserved_out(stack_res), .debug_clock_out(dclk_o), .debug_data_out(ddat_o));

  pmcp_prog_model pmcp_prog_model_inst (
    .mclk_in(mclk_in), .program_voltage_out(vpp),
    .debug_clock_out(pclk), .debug_data_out(pdat));

  always #20 mclk_in = ~mclk_in;

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  // one-cycle strobe, then a bounded wait for grant or refuse
  task automatic acc(input logic wr, input logic [1:0] src, input logic ee,
                     input logic [21:0] a, input logic [7:0] d, input logic exp_g);
    int n;
    n = 0;
    @(posedge mclk_in);
    req        <= 1'b1;
    req_write  <= wr;
    req_src    <= src;
    req_eeprom <= ee;
    req_addr   <= a;
    req_wdata  <= d;
    @(posedge mclk_in);
    req <= 1'b0;
    #1;
    while (grant !== 1'b1 && refuse !== 1'b1 && n < 3) begin
      @(posedge mclk_in);
      #1 n++;
    end
    check(grant === exp_g && refuse === !exp_g, "grant or refuse wrong");
    r_data = rdata;
    r_valid = rdv;
  endtask : acc

  task automatic rdchk(input logic [21:0] a, input logic [7:0] e);
    acc(1'b0, TBL, 1'b0, a, 8'h00, 1'b1);
    check(r_valid === 1'b1 && r_data === e, "read data wrong");
  endtask : rdchk

  task automatic t_reset_values();
    logic [21:0] a [6] = '{22'h300008, 22'h300009, 22'h30000A, 22'h30000B,
                          22'h30000C, 22'h30000D};
    logic [7:0]  e [6] = '{8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};
    for (int i = 0; i < 6; i++) rdchk(a[i], e[i]);
  endtask : t_reset_values

  task automatic t_id();
    rdchk(pmcp_pkg::ID_BASE, 8'hFF);
    acc(1'b1, TBL, 1'b0, pmcp_pkg::ID_LAST, 8'h5A, 1'b1);
    rdchk(pmcp_pkg::ID_LAST, 8'h5A);
  endtask : t_id

  // clear-only writes, region boundaries and boot lock in program mode
  task automatic t_prog_mode();
    pmcp_prog_model_inst.set_program(1'b1);
    repeat (8) @(posedge mclk_in);
    acc(1'b1, EXT, 1'b0, 22'h0007FF, 8'h11, 1'b1);
    acc(1'b1, EXT, 1'b0, 22'h30000A, 8'h0E, 1'b1);
    // all ones tries to set bit 0 again; region 3 bit kept set
    acc(1'b1, EXT, 1'b0, 22'h30000A, 8'hFF, 1'b1);
    rdchk(22'h30000A, 8'h0E);
    acc(1'b1, EXT, 1'b0, 22'h000800, 8'h22, 1'b0);
    acc(1'b1, EXT, 1'b0, 22'h003FFF, 8'h22, 1'b0);
    acc(1'b1, EXT, 1'b0, 22'h004000, 8'h33, 1'b1);
    acc(1'b1, EXT, 1'b0, 22'h30000B, 8'hBF, 1'b1);
    rdchk(22'h30000B, 8'hA0);
    acc(1'b1, EXT, 1'b0, 22'h000000, 8'h44, 1'b0);
    acc(1'b1, EXT, 1'b0, 22'h0007FF, 8'h44, 1'b0);
    pmcp_prog_model_inst.set_program(1'b0);
    repeat (8) @(posedge mclk_in);
    acc(1'b1, CPU, 1'b0, 22'h30000D, 8'h00, 1'b0);
  endtask : t_prog_mode

  task automatic t_eeprom();
    acc(1'b1, CPU, 1'b1, 22'h000000, 8'h55, 1'b1);
    acc(1'b1, EXT, 1'b0, 22'h30000B, 8'h7F, 1'b1);
    acc(1'b1, CPU, 1'b1, 22'h000000, 8'h55, 1'b0);
    acc(1'b1, EXT, 1'b1, 22'h000000, 8'h55, 1'b0);
    acc(1'b0, EXT, 1'b1, 22'h000000, 8'h00, 1'b1);
    acc(1'b1, EXT, 1'b0, 22'h300009, 8'h7F, 1'b1);
    acc(1'b0, EXT, 1'b1, 22'h000000, 8'h00, 1'b0);
    acc(1'b0, CPU, 1'b1, 22'h000000, 8'h00, 1'b1);
  endtask : t_eeprom

  task automatic t_code_table();
    acc(1'b1, EXT, 1'b0, 22'h300008, 8'h0E, 1'b1);
    acc(1'b0, EXT, 1'b0, 22'h000900, 8'h00, 1'b0);
    acc(1'b0, EXT, 1'b0, 22'h004000, 8'h00, 1'b1);
    acc(1'b1, EXT, 1'b0, 22'h30000C, 8'h0E, 1'b1);
    @(posedge mclk_in);
    req_pc <= 21'h004100;
    acc(1'b0, TBL, 1'b0, 22'h000900, 8'h00, 1'b0);
    @(posedge mclk_in);
    req_pc <= 21'h000A00;
    acc(1'b0, TBL, 1'b0, 22'h000900, 8'h00, 1'b1);
    rdchk(pmcp_pkg::ID_BASE, 8'hFF);
  endtask : t_code_table

  task automatic t_unimpl();
    @(posedge mclk_in);
    is_64k <= 1'b0;
    acc(1'b0, EXT, 1'b0, 22'h00C000, 8'h00, 1'b1);
    check(r_valid === 1'b1 && r_data === 8'h00, "48K hole not zero");
    acc(1'b1, EXT, 1'b0, 22'h00C000, 8'h77, 1'b0);
    @(posedge mclk_in);
    is_64k <= 1'b1;
    acc(1'b0, EXT, 1'b0, 22'h010000, 8'h00, 1'b1);
    check(r_valid === 1'b1 && r_data === 8'h00, "top space not zero");
    acc(1'b1, EXT, 1'b0, 22'h1FFFFF, 8'h66, 1'b0);
  endtask : t_unimpl

  task automatic t_config_lock();
    acc(1'b1, EXT, 1'b0, 22'h30000B, 8'hDF, 1'b1);
    acc(1'b1, EXT, 1'b0, 22'h300008, 8'h00, 1'b0);
    rdchk(22'h300008, 8'h0E);
  endtask : t_config_lock

  task automatic t_debug();
    check(pins_res === 1'b0 && dclk_o === 1'b0, "pins reserved with debug off");
    @(posedge mclk_in);
    debug_cfg <= 1'b0;
    repeat (3) @(posedge mclk_in);
    check(dbg_en === 1'b1 && stack_res === 2'h2, "debug not enabled");
    fork
      pmcp_prog_model_inst.send_frame(8'h5A);
      begin
        // first clock pulse of the frame, past the pin filter
        repeat (7) @(posedge mclk_in);
        #1;
        check(dclk_o === 1'b1, "serial clock not passed");
      end
    join
    repeat (8) @(posedge mclk_in);
    check(pins_res === 1'b1 && ddat_o === 1'b1 && dclk_o === 1'b0, "pins");
    debug_cfg <= 1'b1;
    repeat (3) @(posedge mclk_in);
    check(dbg_en === 1'b0 && stack_res === 2'h0, "debug not released");
  endtask : t_debug

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_reset_values();
    t_id();
    t_prog_mode();
    t_eeprom();
    t_code_table();
    t_unimpl();
    t_config_lock();
    t_debug();
    report_and_stop();
  end
endmodule : tb_pmcp_core
`default_nettype wire
